//--- hdl/tks_pkg.sv
package tks_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INTV = 8'h04;
  localparam logic [7:0] A_INDEX = 8'h08;
  localparam logic [7:0] A_CHSEL = 8'h0c;
  localparam logic [7:0] A_DATA = 8'h10;
  localparam logic [7:0] A_FLAGS = 8'h14;
  localparam logic [7:0] A_THRESH = 8'h18;
  localparam logic [7:0] A_LED_EN = 8'h1c;
  localparam logic [7:0] A_LED_ON = 8'h20;
  localparam logic [7:0] A_ACQ_T = 8'h24;
  localparam logic [7:0] A_LED_T = 8'h28;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int C_START = 0;
  localparam int C_MODE = 1;
  localparam int C_TRIG = 2;
  localparam int C_PRE = 4;
  localparam int C_BUSY = 16;
  localparam int FL_THR = 6;
  localparam int FL_OVR = 7;
  localparam int FL_AEND = 8;
  localparam int FL_LEND = 9;
  localparam int NFLAG = 10;
  // ------------------------------------------------------------
  // values after reset and counts
  // ------------------------------------------------------------
  localparam logic [2:0] PRE_RST = 3'h7;
  localparam logic [7:0] INTV_RST = 8'h00;
  localparam logic [15:0] TIME_RST = 16'h00ff;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [6:0] AUTO_LAST = 7'h7f;
  localparam int NSLOT = 6;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  // ------------------------------------------------------------
  // state encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TKS_IDLE = 2'b00,
    TKS_MEAS = 2'b01,
    TKS_NEXT = 2'b11
  } tks_acq_t;
  typedef enum logic [1:0] {
    TKS_PH_OFF = 2'b00,
    TKS_PH_ACQ = 2'b01,
    TKS_PH_LED = 2'b11
  } tks_ph_t;
endpackage : tks_pkg

//--- hdl/tks_top.sv
// How it works
// R1 - with no led enable bit set, in manual mode a one written to the start bit begins a group scan
// R2 - a group has at most six indexed channel slots, one whole group per start
// R3 - hardware clears the start bit when the group is finished
// R4 - each sampled slot sets its own flag on completion
// R5 - index register picks a slot, data register returns its count
// R6 - with no led enable bit set, automatic mode starts scans from the slow-clock interval timer
// R7 - charge clock is the fast clock divided by four
// R8 - charge clock is further divided by the prescale field
// R9 - scanning keeps running in stop mode while both clocks run
// R10 - trigger select zero: every completion wakes the cpu
// R11 - trigger select one: wake only when a count exceeds the threshold
// R12 - channels 0 to 12 each own a shared-led enable bit
// R13 - per-led on bits switch each led during the led phase
// R14 - acquisition phase length is set by the acquisition time count
// R15 - scan longer than the acquisition time raises an overrun flag
// R16 - counter reaching acquisition time raises the phase-end flag
// R17 - led phase follows, its length set by the led time count
// R18 - counter reaching led time raises the led phase-end flag
// R19 - start mode zero is software start, one is timer start
// R20 - auto interval is (interval plus one) times 128 slow clocks
// R21 - prescale value plus one is the divide ratio, 000 to 111
// R22 - after led phase end the acquisition phase restarts
// R23 - flags stay set until software clears them
//
// Implementation choices: the register addresses and the APB register port.
module tks_top #(
  parameter int NCH = 13,
  parameter int RW = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic fast_rc_clock,
  input wire logic slow_rc_clock,
  input wire logic touch_cmp,
  output logic [3:0] chan_sel,
  output logic charge_clk,
  output logic [NCH-1:0] led_drive,
  output logic led_com,
  output logic wake
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [2:0] fast_s_q, slow_s_q;
  logic [1:0] cmp_s_q;
  logic [1:0] q4_q;
  logic [2:0] pre_q, presc_q;
  logic tick4, charge_tick, chg_q;
  logic start_q, mode_q, trig_q;
  logic [7:0] intv_q;
  logic [2:0] idx_q;
  logic [3:0] sel_q [tks_pkg::NSLOT];
  logic [RW-1:0] res_q [tks_pkg::NSLOT];
  logic [RW-1:0] thr_q, cnt_q;
  logic [NCH-1:0] led_en_q, led_on_q, led_drive_q;
  logic [15:0] acq_t_q, led_t_q, pc_q;
  logic [tks_pkg::NFLAG-1:0] flags_q, set_w, clr_w, keep_w;
  logic [14:0] at_q;
  tks_pkg::tks_acq_t st_q;
  tks_pkg::tks_ph_t ph_q;
  logic [2:0] slot_q;
  logic [3:0] cur_sel, chan_q;
  logic wr, rd, wr_ctrl, hit, shared, auto_hit, kick;
  logic meas_end, store, acq_done, acq_end_ev, led_end_ev, ph_start;
  logic wake_q, com_q;
  logic [31:0] rd_d;

  // edge of a synchronised clock, read from second and third stage
  function automatic logic rise(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction : rise

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // rc clocks and comparator are async to sys_clk
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fast_s_q <= 3'h0;
      slow_s_q <= 3'h0;
      cmp_s_q <= 2'h0;
    end else begin
      fast_s_q <= {fast_s_q[1:0], fast_rc_clock};
      slow_s_q <= {slow_s_q[1:0], slow_rc_clock};
      cmp_s_q <= {cmp_s_q[0], touch_cmp};
    end
  end

  // ------------------------------------------------------------
  // charge clock divider
  // ------------------------------------------------------------
  // no stop input: the divider runs whenever the rc clocks toggle
  assign tick4 = rise(fast_s_q) && (q4_q == tks_pkg::DIV4_LAST); // R7 R9
  assign charge_tick = tick4 && (pre_q >= presc_q); // R8 R21

  // >= compare so a lowered prescale never runs the count to wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q4_q <= 2'h0;
      pre_q <= 3'h0;
      chg_q <= 1'b0;
    end else begin
      if (rise(fast_s_q)) begin
        q4_q <= q4_q + 2'h1;
      end
      if (charge_tick) begin
        pre_q <= 3'h0;
        chg_q <= ~chg_q;
      end else if (tick4) begin
        pre_q <= pre_q + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign wr_ctrl = wr && (paddr == tks_pkg::A_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = rd ? rd_d : 32'h0;

  // read mux; unmapped addresses answer with an error
  always_comb begin
    rd_d = 32'h0;
    hit = 1'b1;
    case (paddr)
      tks_pkg::A_CTRL: begin
        rd_d[tks_pkg::C_START] = start_q;
        rd_d[tks_pkg::C_MODE] = mode_q;
        rd_d[tks_pkg::C_TRIG] = trig_q;
        rd_d[tks_pkg::C_PRE +: 3] = presc_q;
        rd_d[tks_pkg::C_BUSY] = (st_q != tks_pkg::TKS_IDLE);
      end
      tks_pkg::A_INTV: rd_d[7:0] = intv_q;
      tks_pkg::A_INDEX: rd_d[2:0] = idx_q;
      tks_pkg::A_CHSEL: begin
        if (idx_q <= tks_pkg::SLOT_LAST) begin
          rd_d[3:0] = sel_q[idx_q];
        end
      end
      tks_pkg::A_DATA: begin
        if (idx_q <= tks_pkg::SLOT_LAST) begin
          rd_d[RW-1:0] = res_q[idx_q]; // R5
        end
      end
      tks_pkg::A_FLAGS: rd_d[tks_pkg::NFLAG-1:0] = flags_q;
      tks_pkg::A_THRESH: rd_d[RW-1:0] = thr_q;
      tks_pkg::A_LED_EN: rd_d[NCH-1:0] = led_en_q;
      tks_pkg::A_LED_ON: rd_d[NCH-1:0] = led_on_q;
      tks_pkg::A_ACQ_T: rd_d[15:0] = acq_t_q;
      tks_pkg::A_LED_T: rd_d[15:0] = led_t_q;
      default: hit = 1'b0;
    endcase
  end

  // configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      trig_q <= 1'b0;
      presc_q <= tks_pkg::PRE_RST;
      intv_q <= tks_pkg::INTV_RST;
      idx_q <= 3'h0;
      thr_q <= '0;
      led_en_q <= '0;
      led_on_q <= '0;
      acq_t_q <= tks_pkg::TIME_RST;
      led_t_q <= tks_pkg::TIME_RST;
      for (int i = 0; i < tks_pkg::NSLOT; i++) begin
        sel_q[i] <= 4'h0;
      end
    end else if (wr) begin
      case (paddr)
        tks_pkg::A_CTRL: begin
          mode_q <= pwdata[tks_pkg::C_MODE]; // R19
          trig_q <= pwdata[tks_pkg::C_TRIG];
          presc_q <= pwdata[tks_pkg::C_PRE +: 3];
        end
        tks_pkg::A_INTV: intv_q <= pwdata[7:0];
        tks_pkg::A_INDEX: idx_q <= pwdata[2:0];
        tks_pkg::A_CHSEL: begin
          if (idx_q <= tks_pkg::SLOT_LAST) begin
            sel_q[idx_q] <= pwdata[3:0]; // R2
          end
        end
        tks_pkg::A_THRESH: thr_q <= pwdata[RW-1:0];
        tks_pkg::A_LED_EN: led_en_q <= pwdata[NCH-1:0]; // R12
        tks_pkg::A_LED_ON: led_on_q <= pwdata[NCH-1:0];
        tks_pkg::A_ACQ_T: acq_t_q <= pwdata[15:0];
        tks_pkg::A_LED_T: led_t_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // start bit: a write of one wins over the hardware clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else if (wr_ctrl && pwdata[tks_pkg::C_START]) begin
      start_q <= 1'b1; // R1
    end else if (acq_done) begin
      start_q <= 1'b0; // R3
    end
  end

  // ------------------------------------------------------------
  // interval timer
  // ------------------------------------------------------------
  // a tick that lands while a group is busy is dropped, not queued
  assign auto_hit = mode_q && !shared && rise(slow_s_q)
    && (at_q == {intv_q, tks_pkg::AUTO_LAST}); // R20

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      at_q <= 15'h0;
    end else if (!mode_q) begin
      at_q <= 15'h0;
    end else if (rise(slow_s_q)) begin
      at_q <= auto_hit ? 15'h0 : at_q + 15'h1; // R6
    end
  end

  // ------------------------------------------------------------
  // group acquisition
  // ------------------------------------------------------------
  assign shared = |led_en_q;
  assign kick = (st_q == tks_pkg::TKS_IDLE) && (shared ? ph_start
    : (mode_q ? auto_hit : start_q)); // R1 R6 R19
  assign cur_sel = sel_q[slot_q];
  // comparator still high from the slot before is ignored until the first tick
  assign meas_end = (cmp_s_q[1] && (cnt_q != '0)) || (&cnt_q);
  assign store = (st_q == tks_pkg::TKS_MEAS) && (cur_sel != 4'h0) && meas_end;
  assign acq_done = (st_q == tks_pkg::TKS_NEXT) && (slot_q == tks_pkg::SLOT_LAST);

  // one slot at a time; an empty slot is skipped without sampling
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= tks_pkg::TKS_IDLE;
      slot_q <= 3'h0;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        tks_pkg::TKS_IDLE: begin
          if (kick) begin
            slot_q <= 3'h0;
            cnt_q <= '0;
            st_q <= tks_pkg::TKS_MEAS;
          end
        end
        tks_pkg::TKS_MEAS: begin
          if (cur_sel == 4'h0 || meas_end) begin
            st_q <= tks_pkg::TKS_NEXT;
          end else if (charge_tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        tks_pkg::TKS_NEXT: begin
          cnt_q <= '0;
          if (slot_q == tks_pkg::SLOT_LAST) begin
            st_q <= tks_pkg::TKS_IDLE; // R2
          end else begin
            slot_q <= slot_q + 3'h1;
            st_q <= tks_pkg::TKS_MEAS;
          end
        end
        default: st_q <= tks_pkg::TKS_IDLE;
      endcase
    end
  end

  // result capture per slot
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < tks_pkg::NSLOT; i++) begin
        res_q[i] <= '0;
      end
    end else if (store) begin
      res_q[slot_q] <= cnt_q; // R5
    end
  end

  // channel select out, zero between slots
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_q <= 4'h0;
    end else begin
      chan_q <= (st_q == tks_pkg::TKS_MEAS) ? cur_sel : 4'h0;
    end
  end

  // ------------------------------------------------------------
  // shared led phases
  // ------------------------------------------------------------
  assign acq_end_ev = (ph_q == tks_pkg::TKS_PH_ACQ) && tick4 && (pc_q == acq_t_q);
  assign led_end_ev = (ph_q == tks_pkg::TKS_PH_LED) && tick4 && (pc_q == led_t_q);
  assign ph_start = shared && ((ph_q == tks_pkg::TKS_PH_OFF) || led_end_ev);

  // phase counter runs on the undivided 4x clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_q <= tks_pkg::TKS_PH_OFF;
      pc_q <= 16'h0;
    end else if (!shared) begin
      ph_q <= tks_pkg::TKS_PH_OFF;
      pc_q <= 16'h0;
    end else begin
      unique case (ph_q)
        tks_pkg::TKS_PH_OFF: begin
          ph_q <= tks_pkg::TKS_PH_ACQ;
          pc_q <= 16'h0;
        end
        tks_pkg::TKS_PH_ACQ: begin
          if (acq_end_ev) begin
            ph_q <= tks_pkg::TKS_PH_LED; // R14 R17
            pc_q <= 16'h0;
          end else if (tick4) begin
            pc_q <= pc_q + 16'h1;
          end
        end
        tks_pkg::TKS_PH_LED: begin
          if (led_end_ev) begin
            ph_q <= tks_pkg::TKS_PH_ACQ; // R22
            pc_q <= 16'h0;
          end else if (tick4) begin
            pc_q <= pc_q + 16'h1;
          end
        end
        default: ph_q <= tks_pkg::TKS_PH_OFF;
      endcase
    end
  end

  // led anodes only in the led phase, com active with them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      led_drive_q <= '0;
      com_q <= 1'b0;
    end else begin
      com_q <= (ph_q == tks_pkg::TKS_PH_LED);
      led_drive_q <= (ph_q == tks_pkg::TKS_PH_LED) ? (led_en_q & led_on_q) : '0; // R13
    end
  end

  // ------------------------------------------------------------
  // flags and wake
  // ------------------------------------------------------------
  always_comb begin
    set_w = '0;
    if (store) begin
      set_w[slot_q] = 1'b1; // R4
      set_w[tks_pkg::FL_THR] = trig_q && (cnt_q > thr_q); // R11
    end
    set_w[tks_pkg::FL_OVR] = acq_end_ev && (st_q != tks_pkg::TKS_IDLE); // R15
    set_w[tks_pkg::FL_AEND] = acq_end_ev; // R16
    set_w[tks_pkg::FL_LEND] = led_end_ev; // R18
  end

  assign clr_w = (wr && paddr == tks_pkg::A_FLAGS) ? pwdata[tks_pkg::NFLAG-1:0] : '0;
  assign keep_w = flags_q & ~clr_w;

  // write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= keep_w | set_w; // R23
    end
  end

  // wake level follows the sticky flags until software clears them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= trig_q ? flags_q[tks_pkg::FL_THR] : (|flags_q[tks_pkg::NSLOT-1:0]); // R10 R11
    end
  end

  assign chan_sel = chan_q;
  assign charge_clk = chg_q;
  assign led_drive = led_drive_q;
  assign led_com = com_q;
  assign wake = wake_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_start_clear: assert property ( // R3
    @(posedge sys_clk) disable iff (rst)
    acq_done && !(wr_ctrl && pwdata[tks_pkg::C_START]) |=> !start_q)
    else $error("start bit not cleared after group");

  a_manual_go: assert property ( // R1
    @(posedge sys_clk) disable iff (rst)
    (st_q == tks_pkg::TKS_IDLE) && !mode_q && start_q && !shared
    |=> (st_q == tks_pkg::TKS_MEAS) && (slot_q == 3'h0))
    else $error("manual start did not begin group");

  a_group_six: assert property ( // R2
    @(posedge sys_clk) disable iff (rst)
    (st_q == tks_pkg::TKS_NEXT) && (slot_q == 3'h5) |=> st_q == tks_pkg::TKS_IDLE)
    else $error("group ran past six slots");

  a_slot_flag: assert property ( // R4
    @(posedge sys_clk) disable iff (rst)
    store |=> flags_q[$past(slot_q)])
    else $error("sampled slot flag not set");

  a_flag_sticky: assert property ( // R23
    @(posedge sys_clk) disable iff (rst)
    !(psel && penable && pwrite && (paddr == tks_pkg::A_FLAGS))
    |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("flag dropped without clear");

  a_div_four: assert property ( // R7
    @(posedge sys_clk) disable iff (rst)
    tick4 |=> !tick4 [*7])
    else $error("divide by four too fast");

  a_auto_mode: assert property ( // R6
    @(posedge sys_clk) disable iff (rst)
    auto_hit && (st_q == tks_pkg::TKS_IDLE) |=> st_q == tks_pkg::TKS_MEAS)
    else $error("timer tick did not start group");

  a_overrun_flag: assert property ( // R15
    @(posedge sys_clk) disable iff (rst)
    acq_end_ev && (st_q != tks_pkg::TKS_IDLE) |=> flags_q[tks_pkg::FL_OVR])
    else $error("overrun not flagged");

  a_led_phase: assert property ( // R13
    @(posedge sys_clk) disable iff (rst)
    (|led_drive_q) |-> $past(ph_q) == tks_pkg::TKS_PH_LED)
    else $error("led driven outside led phase");

  a_phase_loop: assert property ( // R22
    @(posedge sys_clk) disable iff (rst)
    led_end_ev && shared |=> ph_q == tks_pkg::TKS_PH_ACQ && pc_q == 16'h0)
    else $error("acquisition phase not restarted");
endmodule : tks_top

//--- dv/tks_electrode_model.sv
module tks_electrode_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] chan_sel,
  input wire logic charge_clk,
  output logic touch_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // electrode charge model
  // ------------------------------------------------------------
  int ticks;
  logic cc_q;
  // higher channel code is a larger pad, so it needs more charge toggles;
  // comparator drops as soon as the pad is deselected, never holds a stale high
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ticks <= 0;
      cc_q <= 1'b0;
      touch_cmp <= 1'b0;
    end else begin
      cc_q <= charge_clk;
      if (chan_sel == 4'h0) begin
        ticks <= 0;
        touch_cmp <= 1'b0;
      end else begin
        if (cc_q != charge_clk) begin
          ticks <= ticks + 1;
        end
        touch_cmp <= (ticks >= 4 + int'(chan_sel));
      end
    end
  end
endmodule : tks_electrode_model

//--- dv/test_touch_key_scan_controller.sv
module test_touch_key_scan_controller;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // pins and bookkeeping
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fast_rc_clock = 1'b0;
  logic slow_rc_clock = 1'b0;
  logic pready, pslverr, touch_cmp, charge_clk, led_com, wake, err;
  logic [31:0] prdata, rd;
  logic [3:0] chan_sel;
  logic [3:0] cs_q = 4'h0;
  logic [3:0] code [6];
  logic [12:0] led_drive, led_en, led_on;
  integer seed = 32'h33e1;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0, t_cc = 0, gap = 0, n_go = 0, t_go = 0, t_go_prev = 0;
  int i, n, p, k;
  // fast clock 30 ns: one tick4 is 24 cycles; slow clock sped up to 40 ns
  always #2.5 sys_clk = ~sys_clk;
  always #15 fast_rc_clock = ~fast_rc_clock;
  always #20 slow_rc_clock = ~slow_rc_clock;

  tks_top dut_u (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .fast_rc_clock(fast_rc_clock), .slow_rc_clock(slow_rc_clock),
    .touch_cmp(touch_cmp), .chan_sel(chan_sel), .charge_clk(charge_clk),
    .led_drive(led_drive), .led_com(led_com), .wake(wake)
  );
  tks_electrode_model pad_u (
    .sys_clk(sys_clk), .rst(rst), .chan_sel(chan_sel), .charge_clk(charge_clk),
    .touch_cmp(touch_cmp)
  );
  // cycle stamps of charge toggles and of slot starts
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    cs_q <= chan_sel;
    if (chan_sel != 4'h0 && cs_q == 4'h0) begin
      n_go <= n_go + 1;
      t_go_prev <= t_go;
      t_go <= cyc;
    end
  end
  always @(charge_clk) begin
    gap = cyc - t_cc;
    t_cc = cyc;
  end
  // ------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // counts cross clock domains, so they may land one sync step off
  task automatic near(input string what, input int exp, input logic [31:0] got, input int tol);
    num_checks++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no own limit: the watchdog ends a slave that never answers
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdc
  task automatic wait_done();
    int c;
    c = 0;
    do begin
      apb(1'b0, tks_pkg::A_CTRL, 32'h0);
      c++;
    end while (rd[tks_pkg::C_START] !== 1'b0 && c < 20000);
    chk("start cleared", 32'h0, {31'h0, rd[tks_pkg::C_START]});
    repeat (2) @(posedge sys_clk);
  endtask : wait_done
  task automatic wait_led(input logic v);
    int c;
    c = 0;
    while (led_com !== v && c < 20000) begin
      @(posedge sys_clk);
      c++;
    end
    chk("led com", {31'h0, v}, {31'h0, led_com});
  endtask : wait_led
  task automatic tend(input string s);
    $display("test %s done, checks %0d, mismatches %0d", s, num_checks, n_mismatch);
  endtask : tend
  function automatic int exp_cnt(input logic [3:0] c);
    return 4 + int'(c);
  endfunction : exp_cnt
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc("ctrl reset", tks_pkg::A_CTRL, 32'h70);
    rdc("acq time reset", tks_pkg::A_ACQ_T, 32'hff);
    rdc("led time reset", tks_pkg::A_LED_T, 32'hff);
    rdc("interval reset", tks_pkg::A_INTV, 32'h0);
    wr(8'h3c, 32'hffff_ffff);
    chk("unmapped err", 32'h1, {31'h0, err});
    rdc("unmapped read", 8'h3c, 32'h0);
    tend("reset");
    // one slot, every prescale value
    wr(tks_pkg::A_CHSEL, 32'h1);
    for (p = 0; p < 8; p++) begin
      wr(tks_pkg::A_CTRL, 32'(p << tks_pkg::C_PRE) | 32'h1);
      n = 0;
      while (chan_sel === 4'h0 && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      chk("chan sel", 32'h1, {28'h0, chan_sel});
      repeat (3) @(charge_clk);
      near("charge period", 24 * (p + 1), gap, 1);
      @(posedge sys_clk);
      wait_done();
      apb(1'b0, tks_pkg::A_DATA, 32'h0);
      near("single result", exp_cnt(4'h1), rd, 1);
    end
    tend("prescale");
    // full random group
    k = $unsigned($random(seed)) % 4;
    wr(tks_pkg::A_FLAGS, 32'h3ff);
    for (i = 0; i < 6; i++) begin
      code[i] = 4'h1 + 4'($unsigned($random(seed)) % 13);
      wr(tks_pkg::A_INDEX, 32'(i));
      wr(tks_pkg::A_CHSEL, {28'h0, code[i]});
    end
    wr(tks_pkg::A_INDEX, 32'h6);
    wr(tks_pkg::A_CHSEL, 32'h5);
    rdc("slot beyond six", tks_pkg::A_CHSEL, 32'h0);
    wr(tks_pkg::A_CTRL, 32'(k << 4) | 32'h1);
    apb(1'b0, tks_pkg::A_CTRL, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[tks_pkg::C_BUSY]});
    wait_done();
    rdc("slot flags", tks_pkg::A_FLAGS, 32'h3f);
    chk("wake per scan", 32'h1, {31'h0, wake});
    for (i = 0; i < 6; i++) begin
      wr(tks_pkg::A_INDEX, 32'(i));
      apb(1'b0, tks_pkg::A_DATA, 32'h0);
      near("slot result", exp_cnt(code[i]), rd, 1);
    end
    wr(tks_pkg::A_FLAGS, 32'h1);
    rdc("flags kept", tks_pkg::A_FLAGS, 32'h3e);
    wr(tks_pkg::A_CTRL, 32'(k << 4) | 32'h1);
    rdc("flags on restart", tks_pkg::A_FLAGS, 32'h3e);
    wait_done();
    wr(tks_pkg::A_FLAGS, 32'h3ff);
    repeat (2) @(posedge sys_clk);
    chk("wake cleared", 32'h0, {31'h0, wake});
    tend("group");
    // threshold wake, above and below
    wr(tks_pkg::A_THRESH, 32'd100);
    wr(tks_pkg::A_CTRL, 32'h5);
    wait_done();
    chk("wake under thr", 32'h0, {31'h0, wake});
    rdc("no thr flag", tks_pkg::A_FLAGS, 32'h3f);
    wr(tks_pkg::A_FLAGS, 32'h3ff);
    wr(tks_pkg::A_THRESH, 32'd3);
    wr(tks_pkg::A_CTRL, 32'h5);
    wait_done();
    chk("wake over thr", 32'h1, {31'h0, wake});
    rdc("thr flag", tks_pkg::A_FLAGS, 32'h7f);
    tend("threshold");
    // timer start: only slot 0 used, so each slot start is one scan
    for (i = 1; i < 6; i++) begin
      wr(tks_pkg::A_INDEX, 32'(i));
      wr(tks_pkg::A_CHSEL, 32'h0);
    end
    wr(tks_pkg::A_INDEX, 32'h0);
    wr(tks_pkg::A_INTV, 32'h1);
    n = n_go;
    wr(tks_pkg::A_CTRL, 32'h2);
    k = 0;
    while (n_go < n + 3 && k < 10000) begin
      @(posedge sys_clk);
      k++;
    end
    near("auto interval", 2 * 128 * 8, t_go - t_go_prev, 4);
    wr(tks_pkg::A_CTRL, 32'h0);
    wait_done();
    n = n_go;
    repeat (3000) @(posedge sys_clk);
    chk("no start in manual", 32'(n), 32'(n_go));
    tend("timer");
    // shared led cycles
    wr(tks_pkg::A_ACQ_T, 32'd20);
    wr(tks_pkg::A_LED_T, 32'd9);
    wr(tks_pkg::A_FLAGS, 32'h3ff);
    led_on = 13'($random(seed));
    led_en = 13'($random(seed)) | 13'h1;
    wr(tks_pkg::A_LED_ON, {19'h0, led_on});
    wr(tks_pkg::A_LED_EN, {19'h0, led_en});
    wait_led(1'b1);
    repeat (4) @(posedge sys_clk);
    chk("led drive", {19'h0, led_en & led_on}, {19'h0, led_drive});
    n = cyc;
    wait_led(1'b0);
    near("led phase", 10 * 24, cyc - n, 24);
    chk("drive off", 32'h0, {19'h0, led_drive});
    n = cyc;
    wait_led(1'b1);
    near("acq phase", 21 * 24, cyc - n, 24);
    apb(1'b0, tks_pkg::A_FLAGS, 32'h0);
    chk("phase flags", 32'h300, rd & 32'h380);
    wr(tks_pkg::A_LED_EN, 32'h0);
    wait_led(1'b0);
    wait_done();
    // slow pad in a short acquisition window
    wr(tks_pkg::A_CHSEL, 32'hd);
    wr(tks_pkg::A_ACQ_T, 32'd2);
    wr(tks_pkg::A_FLAGS, 32'h3ff);
    wr(tks_pkg::A_LED_EN, {19'h0, led_en});
    wait_led(1'b1);
    wait_led(1'b0);
    wait_led(1'b1);
    apb(1'b0, tks_pkg::A_FLAGS, 32'h0);
    chk("overrun", 32'h380, rd & 32'h380);
    wr(tks_pkg::A_LED_EN, 32'h0);
    wait_led(1'b0);
    tend("shared led");
    summarize();
  end
  // hang guard: worst case run is near 50k cycles, this is 80k
  initial begin
    #400us;
    n_mismatch++;
    $display("Error watchdog expected finish seen hang");
    summarize();
  end
endmodule : test_touch_key_scan_controller
